// File: design/cdc_channel.sv
// Purpose: one crypto descriptor channel with AXI4-Lite register slave
// Assumes: controller answers each request with a done pulse, fetch words
//          arrive as indexed word strobes before done
// Notes:   host starts work by writing the launch pointer register
`timescale 1ns/1ps
module cdc_channel
  import cdc_pkg::*;
(
  input  wire logic               core_clk,    // system clock, 50 MHz
  input  wire logic               nrst,        // async reset, active low
  // AXI4-Lite slave
  input  wire logic [7:0]         s_awaddr,
  input  wire logic               s_awvalid,
  output logic                    s_awready,
  input  wire logic [31:0]        s_wdata,
  input  wire logic [3:0]         s_wstrb,
  input  wire logic               s_wvalid,
  output logic                    s_wready,
  output logic [1:0]              s_bresp,
  output logic                    s_bvalid,
  input  wire logic               s_bready,
  input  wire logic [7:0]         s_araddr,
  input  wire logic               s_arvalid,
  output logic                    s_arready,
  output logic [31:0]             s_rdata,
  output logic [1:0]              s_rresp,
  output logic                    s_rvalid,
  input  wire logic               s_rready,
  // controller side
  output cdc_pkg::cdc_req_t       ctlReq,      // held until done, error or channel reset
  input  wire cdc_pkg::cdc_rsp_t  ctlRsp,      // same clock domain
  // host notification
  output logic                    doneIrq,     // level until a one is written to status bit 0
  output logic                    errIrq       // level until reset
);
  import cdc_pkg::*;

  // ----------------------------------------------------------------
  // state carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    cdc_state_t  st;           // sequencer state
    cdc_req_t    req;          // outstanding controller request
    logic [31:0] cfg;          // configuration bits
    logic [31:0] curPtr;       // current descriptor address
    logic [31:0] launchPtr;    // launch pointer value
    logic        launchPend;   // launch write not yet consumed
    logic [DESC_WORDS*32-1:0] buf_; // descriptor buffer
    logic        isStatic;     // unit statically assigned
    logic        multi;        // digest unit also used
    logic        fromLaunch;   // fetch source was launch pointer
    logic        inChain;      // work in progress belongs to chain
    logic [1:0]  pair;         // current length/pointer pair
    logic        doneFlag;     // completion sticky
    logic        errFlag;      // error sticky
    logic        awHeld;       // write address captured
    logic [7:0]  awAddr;
    logic        wHeld;        // write data captured
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
  } cdc_core_t;

  cdc_core_t s_reg;   // registered state
  cdc_core_t s_next;  // next state

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte-lane merge of a write into a word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : merge

  // pick one buffer word by index
  function automatic logic [31:0] bufWord(input logic [DESC_WORDS*32-1:0] b,
                                          input int idx);
    return b[idx*32 +: 32];
  endfunction : bufWord

  // clamp a packet length to the 32 kbyte cap
  function automatic logic [31:0] capLen(input logic [31:0] l);
    return (l > MAX_LEN) ? MAX_LEN : l;
  endfunction : capLen

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic        wrGo;
    logic        rdGo;
    logic [31:0] hdr;
    logic [31:0] nxt;
    wrGo   = 1'b0;
    rdGo   = 1'b0;
    hdr    = bufWord(s_reg.buf_, 0);
    nxt    = bufWord(s_reg.buf_, DESC_WORDS - 1);
    s_next = s_reg;
    s_next.cfg[CFG_RESET] = 1'b0;            // reset bit self-clears

    // bus channel capture, either order
    if (s_awvalid && !s_reg.awHeld) begin
      s_next.awHeld = 1'b1;
      s_next.awAddr = s_awaddr;
    end
    if (s_wvalid && !s_reg.wHeld) begin
      s_next.wHeld = 1'b1;
      s_next.wData = s_wdata;
      s_next.wStrb = s_wstrb;
    end
    if (s_reg.bValid && s_bready) s_next.bValid = 1'b0;
    if (s_reg.rValid && s_rready) s_next.rValid = 1'b0;

    // register write once address and data both held
    wrGo = s_reg.awHeld && s_reg.wHeld && !s_reg.bValid;
    if (wrGo) begin
      s_next.awHeld = 1'b0;
      s_next.wHeld  = 1'b0;
      s_next.bValid = 1'b1;
      s_next.bResp  = RESP_OKAY;
      if (s_reg.awAddr == OFS_CONFIG) begin
        s_next.cfg = merge(s_reg.cfg, s_reg.wData, s_reg.wStrb);
      end else if (s_reg.awAddr == OFS_STATUS) begin
        // writing ones clears sticky completion, hardware set wins
        if (s_reg.wStrb[0] && s_reg.wData[0]) s_next.doneFlag = 1'b0;
      end else if (s_reg.awAddr == OFS_CUR_PTR) begin
        s_next.curPtr = merge(s_reg.curPtr, s_reg.wData, s_reg.wStrb);
      end else if (s_reg.awAddr == OFS_LAUNCH) begin
        s_next.launchPtr  = merge(s_reg.launchPtr, s_reg.wData, s_reg.wStrb);
        s_next.launchPend = 1'b1;
      end else if (s_reg.awAddr >= OFS_BUF_BASE &&
                   s_reg.awAddr <= OFS_BUF_LAST &&
                   s_reg.awAddr[1:0] == 2'b00) begin
        s_next.buf_[s_reg.awAddr[4:2]*32 +: 32] = merge(
          bufWord(s_reg.buf_, int'(s_reg.awAddr[4:2])),
          s_reg.wData, s_reg.wStrb);
      end else begin
        s_next.bResp = RESP_SLVERR;          // unmapped address
      end
    end

    // register read
    rdGo = s_arvalid && !s_reg.rValid;
    if (rdGo) begin
      s_next.rValid = 1'b1;
      s_next.rResp  = RESP_OKAY;
      s_next.rData  = RST_WORD;
      if (s_araddr == OFS_CONFIG) begin
        s_next.rData = s_reg.cfg;
      end else if (s_araddr == OFS_STATUS) begin
        s_next.rData = {20'h0_0000, s_reg.st, 2'b00, s_reg.pair,
                        s_reg.launchPend, s_reg.isStatic,
                        s_reg.errFlag, s_reg.doneFlag};
      end else if (s_araddr == OFS_CUR_PTR) begin
        s_next.rData = s_reg.curPtr;
      end else if (s_araddr == OFS_LAUNCH) begin
        s_next.rData = s_reg.launchPtr;
      end else if (s_araddr >= OFS_BUF_BASE && s_araddr <= OFS_BUF_LAST &&
                   s_araddr[1:0] == 2'b00) begin
        s_next.rData = bufWord(s_reg.buf_, int'(s_araddr[4:2]));
      end else begin
        s_next.rResp = RESP_SLVERR;
      end
    end

    // descriptor words streamed in during a fetch
    if (s_reg.st == ST_FETCH && ctlRsp.wordValid) begin
      s_next.buf_[ctlRsp.wordIdx*32 +: 32] = ctlRsp.word;
    end

    // sequencer: each request stays up until the controller's done or error, or a channel reset
    if (s_reg.req.valid) begin
      if (ctlRsp.done || ctlRsp.error) begin
        s_next.req.valid = 1'b0;
      end
      if (ctlRsp.error) begin
        s_next.st      = ST_ERROR;
        s_next.errFlag = 1'b1;
      end
    end

    if (!s_reg.req.valid || ctlRsp.done) begin
      if (!ctlRsp.error || !s_reg.req.valid) begin
        case (s_reg.st)
          ST_IDLE: begin
            if (s_reg.launchPend) begin
              s_next.launchPend = 1'b0;
              s_next.fromLaunch = 1'b1;
              s_next.inChain    = 1'b0;
              s_next.req = '{1'b1, OP_FETCH, s_reg.launchPtr,
                             32'(DESC_WORDS * 4), 32'h0, 1'b0};
              s_next.st  = ST_FETCH;
            end
          end
          ST_FETCH: begin
            if (s_reg.req.valid) begin
              s_next.curPtr = s_reg.req.addr;
              s_next.isStatic = ctlRsp.staticUnit;
              s_next.multi    = hdr[HDR_MULTI];
              s_next.pair     = 2'd0;
              if (ctlRsp.staticUnit) begin
                s_next.req = '{1'b1, OP_RST_UNIT, 32'h0, 32'h0, 32'h0, 1'b0};
                s_next.st  = ST_URST;
              end else begin
                s_next.req = '{1'b1, OP_REQ_UNIT, 32'h0, 32'h0, hdr, 1'b0};
                s_next.st  = ST_REQU;
              end
            end
          end
          ST_REQU: begin
            if (s_reg.multi) begin
              s_next.req = '{1'b1, OP_REQ_DIG, 32'h0, 32'h0, hdr, 1'b1};
              s_next.st  = ST_REQD;
            end else begin
              s_next.req = '{1'b1, OP_RST_UNIT, 32'h0, 32'h0, 32'h0, 1'b0};
              s_next.st  = ST_URST;
            end
          end
          ST_REQD: begin
            s_next.req = '{1'b1, OP_RST_UNIT, 32'h0, 32'h0, 32'h0, 1'b0};
            s_next.st  = ST_URST;
          end
          ST_URST: begin
            if (ctlRsp.unitResetDone) begin
              s_next.req = '{1'b1, OP_MODE, 32'h0, 32'h0, hdr, s_reg.multi};
              s_next.st  = ST_MODE;
            end
          end
          ST_MODE: begin
            s_next.req = '{1'b1, OP_KEY, bufWord(s_reg.buf_, 2),
                           bufWord(s_reg.buf_, 1), 32'h0, 1'b0};
            s_next.st  = ST_KEY;
          end
          ST_KEY, ST_MOVEOUT: begin
            // program data size ahead of every FIFO write
            s_next.req = '{1'b1, OP_DSIZE, 32'h0,
              capLen(bufWord(s_reg.buf_, 3)), 32'h0, 1'b0};
            s_next.st  = ST_DSIZE;
            if (s_reg.st == ST_MOVEOUT) begin
              s_next.req = '{1'b1, OP_RELEASE, 32'h0, 32'h0, 32'h0, 1'b0};
              s_next.st  = ST_RELEASE;
              if (s_reg.isStatic) begin
                s_next.req.valid = 1'b0;
                if (ctlRsp.unitInputDone) begin
                  s_next.req = '{1'b1, OP_CLR_IRQ, 32'h0, 32'h0, 32'h0, 1'b0};
                end
              end
            end
          end
          ST_DSIZE: begin
            s_next.req = '{1'b1, OP_MEM2UNIT, bufWord(s_reg.buf_, 4),
              capLen(bufWord(s_reg.buf_, 3)), 32'h0, s_reg.multi};
            s_next.st  = ST_MOVEIN;
          end
          ST_MOVEIN: begin
            s_next.req = '{1'b1, OP_UNIT2MEM, bufWord(s_reg.buf_, 6),
              capLen(bufWord(s_reg.buf_, 5)), 32'h0, s_reg.multi};
            s_next.st  = ST_MOVEOUT;
          end
          ST_RELEASE: begin
            if (s_reg.cfg[CFG_CHAIN] && nxt != 32'h0) begin
              s_next.fromLaunch = 1'b0;
              s_next.inChain    = 1'b1;
              s_next.req = '{1'b1, OP_FETCH, nxt,
                             32'(DESC_WORDS * 4), 32'h0, 1'b0};
              s_next.st  = ST_FETCH;
            end else if (s_reg.launchPend) begin
              s_next.launchPend = 1'b0;
              s_next.fromLaunch = 1'b1;
              s_next.inChain    = 1'b1;
              s_next.req = '{1'b1, OP_FETCH, s_reg.launchPtr,
                             32'(DESC_WORDS * 4), 32'h0, 1'b0};
              s_next.st  = ST_FETCH;
            end else begin
              s_next.st = ST_NOTIFY;
              if (s_reg.cfg[CFG_WRBACK]) begin
                s_next.req = '{1'b1, OP_WRBACK, s_reg.curPtr, 32'h4,
                               hdr | (32'h1 << HDR_DONEBIT), 1'b0};
              end
            end
          end
          ST_NOTIFY: begin
            s_next.doneFlag = 1'b1;
            s_next.st       = ST_IDLE;
          end
          ST_ERROR: begin
            if (s_reg.cfg[CFG_RESET]) begin
              s_next.st      = ST_IDLE;
              s_next.errFlag = 1'b0;
            end
          end
          default: s_next.st = ST_IDLE;
        endcase
      end
    end

    // software channel reset aborts any work; an error raised in the
    // same cycle wins, so the channel still halts in the error state
    if (s_reg.cfg[CFG_RESET] && s_reg.st != ST_ERROR &&
        !(s_reg.req.valid && ctlRsp.error)) begin
      s_next.st        = ST_IDLE;
      s_next.req.valid = 1'b0;
      s_next.errFlag   = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      // idle, no request up, empty buffer, all flags clear
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign s_awready = !s_reg.awHeld;
  assign s_wready  = !s_reg.wHeld;
  assign s_bvalid  = s_reg.bValid;
  assign s_bresp   = s_reg.bResp;
  assign s_arready = !s_reg.rValid;
  assign s_rvalid  = s_reg.rValid;
  assign s_rdata   = s_reg.rData;
  assign s_rresp   = s_reg.rResp;
  assign ctlReq    = s_reg.req;
  assign doneIrq   = s_reg.doneFlag;
  assign errIrq    = s_reg.errFlag;

endmodule : cdc_channel

// File: pkg/cdc_pkg.sv
// Purpose: shared constants and carrier types for the crypto descriptor channel
// Assumes: 32-bit AXI4-Lite register bus, 32-bit system addresses
// Notes:   offsets are byte addresses of aligned words
package cdc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_CONFIG      = 8'h00; // channel configuration
  localparam logic [7:0]  OFS_STATUS      = 8'h04; // channel status
  localparam logic [7:0]  OFS_CUR_PTR     = 8'h08; // current pointer reg
  localparam logic [7:0]  OFS_LAUNCH      = 8'h0c; // launch pointer reg
  localparam logic [7:0]  OFS_BUF_BASE    = 8'h20; // descriptor buffer
  localparam logic [7:0]  OFS_BUF_LAST    = 8'h3c; // last buffer word
  localparam logic [31:0] RST_WORD        = 32'h0000_0000;

  // configuration bit positions
  localparam int CFG_CHAIN   = 0;  // follow next-descriptor pointer
  localparam int CFG_WRBACK  = 1;  // header writeback on completion
  localparam int CFG_IRQDONE = 2;  // interrupt on each descriptor; no logic reads it, doneIrq is set once per chain
  localparam int CFG_RESET   = 3;  // self-clearing channel reset

  // descriptor layout
  localparam int DESC_WORDS  = 8;  // header, 3 length/pointer pairs, next
  localparam int HDR_MULTI   = 4;  // header bit: add digest unit snooping
  localparam int HDR_DONEBIT = 31; // header bit set on writeback
  localparam logic [31:0] MAX_LEN = 32'h0000_8000; // 32 kbyte packet cap

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // channel sequencer states
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_FETCH   = 4'b0001,
    ST_REQU    = 4'b0010,
    ST_REQD    = 4'b0011,
    ST_URST    = 4'b0100,
    ST_MODE    = 4'b0101,
    ST_KEY     = 4'b0110,
    ST_DSIZE   = 4'b0111,
    ST_MOVEIN  = 4'b1000,
    ST_MOVEOUT = 4'b1001,
    ST_RELEASE = 4'b1010,
    ST_NOTIFY  = 4'b1011,
    ST_ERROR   = 4'b1100
  } cdc_state_t;

  // controller request codes
  typedef enum logic [3:0] {
    OP_NONE     = 4'h0,
    OP_FETCH    = 4'h1,
    OP_REQ_UNIT = 4'h2,
    OP_REQ_DIG  = 4'h3,
    OP_RST_UNIT = 4'h4,
    OP_MODE     = 4'h5,
    OP_KEY      = 4'h6,
    OP_DSIZE    = 4'h7,
    OP_MEM2UNIT = 4'h8,
    OP_UNIT2MEM = 4'h9,
    OP_RELEASE  = 4'ha,
    OP_WRBACK   = 4'hb,
    OP_CLR_IRQ  = 4'hc
  } cdc_op_t;

  // request from channel to controller
  typedef struct packed {
    logic        valid;
    cdc_op_t     op;
    logic [31:0] addr;
    logic [31:0] len;
    logic [31:0] data;
    logic        snoop;
  } cdc_req_t;

  // answer from controller to channel
  typedef struct packed {
    logic        done;
    logic        error;
    logic        staticUnit;
    logic        unitResetDone;
    logic        unitInputDone;
    logic [2:0]  wordIdx;
    logic [31:0] word;
    logic        wordValid;
  } cdc_rsp_t;

endpackage : cdc_pkg

// File: bench/cdc_channel_props.sv
// Purpose: concurrent checks on the channel's controller side
// Assumes: one clock, async active-low reset
// Notes:   helper flags track the last fetch and the unit reset
`timescale 1ns/1ps
module cdc_channel_props
  import cdc_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              nrst,
  input wire cdc_pkg::cdc_req_t ctlReq,
  input wire cdc_pkg::cdc_rsp_t ctlRsp,
  input wire logic              doneIrq,
  input wire logic              errIrq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [31:0] fetchAddr_reg; // address of the last fetch
  logic        rstSeen_reg;   // unit reset finished for this descriptor
  // ---------------------------------------------------------------
  // helper state
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fetchAddr_reg <= '0;
      rstSeen_reg <= 1'b0;
    end else if (ctlReq.valid && ctlRsp.done) begin
      if (ctlReq.op == OP_FETCH) fetchAddr_reg <= ctlReq.addr;
      rstSeen_reg <= (ctlReq.op == OP_RST_UNIT) ||
                     (rstSeen_reg && ctlReq.op != OP_FETCH);
    end
  end
  sequence sReq(cdc_op_t o);
    ctlReq.valid && ctlReq.op == o;
  endsequence
  sequence sDone(cdc_op_t o);
    ctlReq.valid && ctlReq.op == o && ctlRsp.done;
  endsequence
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  a_req_stable: assert property (ctlReq.valid && !ctlRsp.done &&
    !ctlRsp.error |=> $stable(ctlReq)) else $error("request moved");
  a_unit_request: assert property (sDone(OP_FETCH) ##0
    !ctlRsp.staticUnit |=> sReq(OP_REQ_UNIT)) else $error("no unit req");
  a_static_skip: assert property (sDone(OP_FETCH) ##0
    ctlRsp.staticUnit |=> sReq(OP_RST_UNIT)) else $error("static skip");
  a_mode_after_rst: assert property (sReq(OP_MODE)
    |-> rstSeen_reg) else $error("mode before reset");
  a_key_after_mode: assert property (sDone(OP_MODE)
    |=> sReq(OP_KEY)) else $error("key not after mode");
  a_size_order: assert property (sDone(OP_KEY)
    |=> sReq(OP_DSIZE)) else $error("size order");
  a_move_after_size: assert property (sDone(OP_DSIZE)
    |=> sReq(OP_MEM2UNIT)) else $error("move before size");
  a_len_cap: assert property (sReq(OP_DSIZE)
    or sReq(OP_MEM2UNIT) or sReq(OP_UNIT2MEM)
    |-> ctlReq.len <= MAX_LEN) else $error("length above cap");
  a_wrback_addr: assert property (sReq(OP_WRBACK) |->
    ctlReq.addr == fetchAddr_reg && ctlReq.data[HDR_DONEBIT])
    else $error("writeback address");
  a_err_irq: assert property (ctlReq.valid && ctlRsp.error
    |-> ##[1:2] errIrq) else $error("no error irq");
  a_done_irq: assert property (sDone(OP_WRBACK)
    |-> ##[1:2] doneIrq) else $error("no done irq");
endmodule : cdc_channel_props

bind cdc_channel cdc_channel_props u_props (.core_clk(core_clk),
  .nrst(nrst), .ctlReq(ctlReq), .ctlRsp(ctlRsp), .doneIrq(doneIrq),
  .errIrq(errIrq));

// File: bench/cdc_ctl_model.sv
// Purpose: controller, units and memory seen from the channel
// Assumes: memory image preloaded by the bench
// Notes:   answers after a set latency, may answer with an error
`timescale 1ns/1ps
module cdc_ctl_model
  import cdc_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire cdc_pkg::cdc_req_t ctlReq,
  output cdc_pkg::cdc_rsp_t      ctlRsp,
  input  wire logic [3:0]        lat,
  input  wire logic              stMode,
  input  wire cdc_pkg::cdc_op_t  errOp
);
  logic [31:0] mem [logic [31:0]]; // memory image
  cdc_req_t    logQ [$];           // requests answered so far
  int          cnt;                // cycles into the request
  int          fin;                // cycle of the answer
  // answer requests; the word line toggles while released
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctlRsp <= '0;
      cnt <= 0;
    end else begin
      ctlRsp.done <= 1'b0;
      ctlRsp.error <= 1'b0;
      ctlRsp.wordValid <= 1'b0;
      ctlRsp.word <= ~ctlRsp.word;
      ctlRsp.staticUnit <= stMode;
      fin = (ctlReq.op == OP_FETCH) ? 8 + lat : int'(lat);
      if (ctlReq.valid && !ctlRsp.done && !ctlRsp.error) begin
        cnt <= cnt + 1;
        if (ctlReq.op == OP_FETCH && cnt < 8) begin
          ctlRsp.wordValid <= 1'b1;
          ctlRsp.wordIdx <= cnt[2:0];
          ctlRsp.word <= mem[ctlReq.addr + 32'(4 * cnt)];
        end
        if (cnt >= fin) begin
          cnt <= 0;
          logQ.push_back(ctlReq);
          if (ctlReq.op == errOp) ctlRsp.error <= 1'b1;
          else ctlRsp.done <= 1'b1;
          if (ctlReq.op == OP_RST_UNIT) ctlRsp.unitResetDone <= 1'b1;
          if (ctlReq.op == OP_MEM2UNIT) ctlRsp.unitInputDone <= 1'b1;
          if (ctlReq.op == OP_FETCH) begin
            ctlRsp.unitResetDone <= 1'b0;
            ctlRsp.unitInputDone <= 1'b0;
          end
        end
      end
    end
  end
endmodule : cdc_ctl_model

// File: bench/tb.sv
// Purpose: self-checking bench for the crypto descriptor channel
// Assumes: controller model logs every answered request
// Notes:   expected request streams are built in a queue
`timescale 1ns/1ps
module tb;
  import cdc_pkg::*;
  typedef struct packed {
    cdc_op_t op; logic [31:0] addr, len, data; logic [2:0] m;
  } cdc_exp_t;
  logic        core_clk = 0, nrst = 0;
  logic [7:0]  s_awaddr = '0, s_araddr = '0;
  logic [31:0] s_wdata = '0, s_rdata, rd, rnd = 32'd30;
  logic [3:0]  s_wstrb = 4'hf, lat = '0;
  logic        s_awvalid = 0, s_wvalid = 0, s_bready = 0;
  logic        s_arvalid = 0, s_rready = 0, stMode = 0;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]  s_bresp, s_rresp, rs;
  logic        doneIrq, errIrq;
  cdc_req_t    ctlReq;
  cdc_rsp_t    ctlRsp;
  cdc_op_t     errOp = OP_NONE;
  cdc_exp_t    expQ [$];
  int          err_total = 0, checked = 0, cyc = 0;
  always #10 core_clk = ~core_clk;
  cdc_channel u_cdc_channel (.core_clk, .nrst, .s_awaddr, .s_awvalid,
    .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
    .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready, .ctlReq, .ctlRsp, .doneIrq, .errIrq);
  cdc_ctl_model u_cdc_ctl_model (.core_clk, .nrst, .ctlReq, .ctlRsp,
    .lat, .stMode, .errOp);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] g, e, input string m);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  // one AXI write; settled values are read at the falling edge and
  // acted on at the next rising edge, the timeout ends a hang
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic awOk, wOk, bOk;
    @(posedge core_clk);
    s_awaddr <= a; s_wdata <= d; s_awvalid <= 1; s_wvalid <= 1;
    s_bready <= 1;
    do begin
      @(negedge core_clk);
      awOk = s_awvalid && s_awready;
      wOk = s_wvalid && s_wready;
      bOk = s_bvalid;
      rs = s_bresp;
      @(posedge core_clk);
      if (awOk) s_awvalid <= 0;
      if (wOk) s_wvalid <= 0;
    end while (!bOk);
    s_bready <= 0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    logic arOk, rOk;
    @(posedge core_clk);
    s_araddr <= a; s_arvalid <= 1; s_rready <= 1;
    do begin
      @(negedge core_clk);
      arOk = s_arvalid && s_arready;
      rOk = s_rvalid;
      rd = s_rdata; rs = s_rresp;
      @(posedge core_clk);
      if (arOk) s_arvalid <= 0;
    end while (!rOk);
    s_rready <= 0;
  endtask : axr
  task automatic pe(cdc_op_t o, logic [31:0] a = 0, l = 0, d = 0,
                    logic [2:0] m = 0);
    expQ.push_back('{o, a, l, d, m});
  endtask : pe
  // build a descriptor in memory and its expected request stream
  task automatic mk(input logic [31:0] a, h, nx, input logic st);
    logic [31:0] w [8];
    logic [31:0] lenCap; // data size after the 32 kbyte cap
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      w[i] = {rnd[31:2], 2'b00};
    end
    w[0] = h; w[7] = nx;
    w[3] = h[0] ? 32'h0001_0000 : {17'h0, w[3][14:0]};
    lenCap = h[0] ? MAX_LEN : w[3];
    w[5] = {17'h0, w[5][14:0]};
    for (int i = 0; i < 8; i++) u_cdc_ctl_model.mem[a + 32'(4 * i)] = w[i];
    pe(OP_FETCH, a, 0, 0, 3'b001);
    if (!st) pe(OP_REQ_UNIT);
    if (!st && h[HDR_MULTI]) pe(OP_REQ_DIG);
    pe(OP_RST_UNIT);
    pe(OP_MODE);
    pe(OP_KEY, w[2], w[1], 0, 3'b011);
    pe(OP_DSIZE, 0, lenCap, 0, 3'b010);
    pe(OP_MEM2UNIT, w[4], lenCap, 0, 3'b011);
    pe(OP_UNIT2MEM, w[6], w[5], 0, 3'b011);
    pe(st ? OP_CLR_IRQ : OP_RELEASE);
  endtask : mk
  // wait for the stream, then compare it request by request
  task automatic run(input string t);
    cdc_exp_t e;
    cdc_req_t g;
    for (int n = 0; n < 3000; n++) begin
      if (u_cdc_ctl_model.logQ.size() >= expQ.size()) break;
      @(negedge core_clk);
    end
    repeat (20) @(negedge core_clk);
    chk(u_cdc_ctl_model.logQ.size(), expQ.size(), "request count");
    while (expQ.size() > 0 && u_cdc_ctl_model.logQ.size() > 0) begin
      e = expQ.pop_front();
      g = u_cdc_ctl_model.logQ.pop_front();
      chk(g.op, e.op, "op");
      if (e.m[0]) chk(g.addr, e.addr, "addr");
      if (e.m[1]) chk(g.len, e.len, "len");
      if (e.m[2]) chk(g.data, e.data, "data");
    end
    expQ.delete();
    u_cdc_ctl_model.logQ.delete();
    $display("test %s done, mismatches %0d", t, err_total);
  endtask : run
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    axr(OFS_CUR_PTR);
    chk(rd, RST_WORD, "pointer reset");
    axr(OFS_LAUNCH);
    chk(rd, RST_WORD, "launch reset");
    axr(8'h10);
    chk(rs, RESP_SLVERR, "unmapped");
    axw(OFS_CUR_PTR, 32'h0000_1230);
    axr(OFS_CUR_PTR);
    chk(rd, 32'h0000_1230, "pointer rw");
    axw(OFS_CONFIG, 32'h0000_0002);
    mk(32'h100, 32'h0000_0011, 0, 0);
    pe(OP_WRBACK, 32'h100, 0, 32'h8000_0011, 3'b101);
    axw(OFS_LAUNCH, 32'h100);
    run("single");
    chk(doneIrq, 1, "done irq");
    axr(OFS_CUR_PTR);
    chk(rd, 32'h100, "current pointer");
    axw(OFS_STATUS, 32'h1);
    chk(doneIrq, 0, "done clear");
    stMode <= 1; lat <= 4'h3;
    axw(OFS_CONFIG, 32'h0000_0003);
    mk(32'h200, 32'h0000_0020, 32'h300, 1);
    mk(32'h300, 32'h0000_0001, 0, 1);
    pe(OP_WRBACK, 32'h300, 0, 32'h8000_0001, 3'b101);
    axw(OFS_LAUNCH, 32'h200);
    run("chain");
    chk(doneIrq, 1, "chain irq");
    axw(OFS_STATUS, 32'h1);
    stMode <= 0; lat <= 4'h2;
    axw(OFS_CONFIG, 32'h0000_0002);
    mk(32'h400, 32'h0000_0010, 0, 0);
    mk(32'h500, 32'h0000_0000, 0, 0);
    pe(OP_WRBACK, 32'h500, 0, 32'h8000_0000, 3'b101);
    axw(OFS_LAUNCH, 32'h400);
    for (int n = 0; n < 500 && u_cdc_ctl_model.logQ.size() < 3; n++)
      @(negedge core_clk);
    axw(OFS_LAUNCH, 32'h500);
    run("pending");
    axw(OFS_STATUS, 32'h1);
    errOp <= OP_MEM2UNIT;
    mk(32'h600, 32'h0000_0000, 0, 0);
    void'(expQ.pop_back());
    void'(expQ.pop_back());
    axw(OFS_LAUNCH, 32'h600);
    run("error");
    chk(errIrq, 1, "error irq");
    chk(doneIrq, 0, "no done irq");
    errOp <= OP_NONE;
    axw(OFS_CONFIG, 32'h0000_0008);
    repeat (2) @(negedge core_clk);
    chk(errIrq, 0, "error clear");
    report_and_stop();
  end
endmodule : tb
